/* File: design/asp_init_map.vh */
// Register map, field positions and timing counts of the serial port sequencer.
// Assumes inclusion by the port core and its sample rate generator.
`ifndef ASP_INIT_MAP_VH
`define ASP_INIT_MAP_VH

`define ASP_ADDR_CTRL       4'h0
`define ASP_ADDR_SRG        4'h1
`define ASP_ADDR_PIN        4'h2
`define ASP_ADDR_TXDATA     4'h3
`define ASP_ADDR_RXDATA     4'h4
`define ASP_ADDR_STATUS     4'h5

// Control register bits
`define ASP_CTL_RECEIVER_RESET_N        0
`define ASP_CTL_TRANSMITTER_RESET_N        1
`define ASP_CTL_CLOCK_GEN_RESET_N        2
`define ASP_CTL_FRAME_GEN_RESET_N        3
`define ASP_CTL_TRANSMIT_INTERRUPT_MODE_LO    4
`define ASP_CTL_TRANSMIT_INTERRUPT_MODE_HI    5
`define ASP_CTL_RECEIVE_INTERRUPT_MODE_LO    6
`define ASP_CTL_RECEIVE_INTERRUPT_MODE_HI    7
// Rate generator register fields
`define ASP_SRG_DIV_LO      0
`define ASP_SRG_DIV_HI      7
`define ASP_SRG_GEN_CLOCK_MODE_SELECT       8
`define ASP_SRG_FRAME_GENERATOR_MODE        9
// Pin control register fields
`define ASP_PIN_PIN_CLOCK_MODE_EXTENSION      0
// Status register bits
`define ASP_ST_TRANSMIT_READY_FLAG         0
`define ASP_ST_RECEIVE_READY_FLAG         1
`define ASP_ST_SHIFT_REG_NOT_EMPTY_FLAG       2
`define ASP_ST_TRANSMIT_SYNC_ERROR     3

`define ASP_INTM_READY      2'h0
`define ASP_INTM_FSYNC      2'h2
`define ASP_INTM_SYNCERR    2'h3

`define ASP_CTRL_RESET      8'h00
`define ASP_SRG_RESET       10'h001
`define ASP_TXSR_DEFAULT    16'h0000
`define ASP_SYNC_WINDOW     2'h2
`define ASP_FSG_DELAY       4'h7

`endif

/* File: design/asp_srg.v */
// Sample rate generator: divided bit clock and frame sync generator.
// Assumes one system clock; source clock and pin clock already synchronised.
`timescale 1ns/1ps
`default_nettype none

module asp_srg #(
   parameter DIV_W = 8
) (
   input  wire             mclk,
   input  wire             rst_n,
   input  wire             clk_rst_n,
   input  wire             frame_rst_n,
   input  wire             src_rise,
   input  wire [DIV_W-1:0] divider,
   output reg              bit_clk_r,
   output reg              bit_rise_r,
   output reg              frame_sync_r
);
`include "asp_init_map.vh"

   reg [DIV_W-1:0] cnt_r;
   reg [3:0]       fdel_r;
   reg             started_r;

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r        <= {DIV_W{1'b0}};
         bit_clk_r    <= 1'b0;
         bit_rise_r   <= 1'b0;
         started_r    <= 1'b0;
         frame_sync_r <= 1'b0;
         fdel_r       <= 4'h0;
      end else begin
         bit_rise_r <= 1'b0;
         if (!clk_rst_n) begin
            cnt_r        <= {DIV_W{1'b0}};
            bit_clk_r    <= 1'b0; // R19
            started_r    <= 1'b0;
            frame_sync_r <= 1'b0; // R19
            fdel_r       <= 4'h0;
         end else if (src_rise) begin
            if (!started_r || cnt_r == divider) begin
               // Period is divider+1 source edges
               cnt_r      <= {DIV_W{1'b0}}; // R5
               bit_clk_r  <= 1'b1;
               bit_rise_r <= 1'b1;
               started_r  <= 1'b1;
            end else begin
               cnt_r <= cnt_r + {{(DIV_W-1){1'b0}}, 1'b1};
               if (cnt_r == (divider >> 1))
                  bit_clk_r <= 1'b0;
            end
         end
         if (bit_rise_r) begin
            if (!frame_rst_n) begin
               fdel_r       <= 4'h0;
               frame_sync_r <= 1'b0;
            end else if (fdel_r != `ASP_FSG_DELAY) begin
               fdel_r       <= fdel_r + 4'h1; // R12
               frame_sync_r <= 1'b0;
            end else begin
               frame_sync_r <= 1'b1; // R12
            end
         end else if (!frame_rst_n) begin
            frame_sync_r <= 1'b0;
         end
      end
   end

endmodule

`default_nettype wire

/* File: design/asp_init_core.v */
// Serial port start-up sequencer with register port.
// Assumes pins from outside the mclk domain; software follows the start-up order.
`timescale 1ns/1ps
`default_nettype none

//
// Operation
// R1: Program control only with everything in reset
// R2: Software waits two clocks for synchronisation
// R3: Source clock chosen by mode and extension
// R4: Software sets clock reset then waits
// R5: Bit clock divides source by divider plus one
// R6: First enable may flag spurious sync error
// R7: Clearing transmit reset clears sync error
// R8: DMA started before sections leave reset
// R9: Released section issues events, interrupts, ready
// R10: Mode zero syncs per copy, one uses generator
// R11: Load transmit data before starting frame generator
// R12: Frame sync after seven to eight clocks
// R13: Transmitter idles until external frame sync
// R14: Early sync shifts default content out
// R15: Software releases transmitter after first sync
// R16: Sync-detect interrupt only out of reset
// R17: Pin switching only with external masters
// R18: All reset bits read zero after reset
// R19: Clock reset holds clock and sync low
// R20: Transmitter release raises transmit ready
module asp_init_core #(
   parameter DIV_W  = 8,
   parameter DATA_W = 16
) (
   input  wire              mclk,
   input  wire              rst_n,
   input  wire [3:0]        addr,
   input  wire [15:0]       wdata,
   input  wire              wr,
   input  wire              rd,
   output reg  [15:0]       rdata_r,
   input  wire              src_clk_pin,
   input  wire              ext_bit_clk_pin,
   input  wire              ext_fsx_pin,
   input  wire              ext_fsr_pin,
   input  wire              rx_data_pin,
   output reg               tx_data_r,
   output reg               tx_data_oe_r,
   output reg               bit_clk_out_r,
   output reg               fsx_out_r,
   output reg               fsr_out_r,
   output reg               transmit_dma_event_r,
   output reg               receive_dma_event_r,
   output reg               transmit_interrupt_r,
   output reg               receive_interrupt_r
);
`include "asp_init_map.vh"

   reg [7:0]        ctrl_r;
   reg [9:0]        srg_r;
   reg              pin_clock_mode_extension_r;
   reg [DATA_W-1:0] txd_r;
   reg [DATA_W-1:0] txsr_r;
   reg [DATA_W-1:0] rxsr_r;
   reg [DATA_W-1:0] rxd_r;
   reg [4:0]        txcnt_r;
   reg [4:0]        rxcnt_r;
   reg              transmit_ready_flag_r;
   reg              receive_ready_flag_r;
   reg              shift_reg_not_empty_flag_r;
   reg              transmit_sync_error_r;
   reg              first_en_r;
   reg [1:0]        errwin_r;
   reg              tx_active_r;
   reg              rx_active_r;
   reg              transmitter_reset_n_q_r;
   reg              first_sync_r;
   reg              fsx_prev_r;
   reg              fsr_prev_r;
   reg              bclk_prev_r;
   reg              srcp_prev_r;
   reg [1:0]        src_s_r;
   reg [1:0]        bclk_s_r;
   reg [1:0]        fsx_s_r;
   reg [1:0]        fsr_s_r;
   reg [1:0]        dr_s_r;

   wire clk_rst_n   = ctrl_r[`ASP_CTL_CLOCK_GEN_RESET_N];
   wire frame_rst_n = ctrl_r[`ASP_CTL_FRAME_GEN_RESET_N];
   wire transmitter_reset_n_n      = ctrl_r[`ASP_CTL_TRANSMITTER_RESET_N];
   wire receiver_reset_n_n      = ctrl_r[`ASP_CTL_RECEIVER_RESET_N];
   wire frame_generator_mode        = srg_r[`ASP_SRG_FRAME_GENERATOR_MODE];
   wire [1:0] transmit_interrupt_mode = ctrl_r[`ASP_CTL_TRANSMIT_INTERRUPT_MODE_HI:`ASP_CTL_TRANSMIT_INTERRUPT_MODE_LO];
   wire [1:0] receive_interrupt_mode = ctrl_r[`ASP_CTL_RECEIVE_INTERRUPT_MODE_HI:`ASP_CTL_RECEIVE_INTERRUPT_MODE_LO];

   // Pins are asynchronous to mclk: two stages before use
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         src_s_r  <= 2'h0;
         bclk_s_r <= 2'h0;
         fsx_s_r  <= 2'h0;
         fsr_s_r  <= 2'h0;
         dr_s_r   <= 2'h0;
      end else begin
         src_s_r  <= {src_s_r[0], src_clk_pin};
         bclk_s_r <= {bclk_s_r[0], ext_bit_clk_pin};
         fsx_s_r  <= {fsx_s_r[0], ext_fsx_pin};
         fsr_s_r  <= {fsr_s_r[0], ext_fsr_pin};
         dr_s_r   <= {dr_s_r[0], rx_data_pin};
      end
   end

   // Source select: mclk when both bits agree (both low or both high), else the pin clock
   wire src_sel_pin = srg_r[`ASP_SRG_GEN_CLOCK_MODE_SELECT] ^ pin_clock_mode_extension_r; // R3
   wire src_rise    = src_sel_pin ? (src_s_r[1] & ~srcp_prev_r) : 1'b1; // R3

   wire       gen_clk;
   wire       gen_rise;
   wire       gen_fs;

   asp_srg #(
      .DIV_W (DIV_W)
   ) u_srg (
      .mclk         (mclk),
      .rst_n        (rst_n),
      .clk_rst_n    (clk_rst_n),
      .frame_rst_n  (frame_rst_n),
      .src_rise     (src_rise),
      .divider      (srg_r[`ASP_SRG_DIV_HI:`ASP_SRG_DIV_LO]),
      .bit_clk_r    (gen_clk),
      .bit_rise_r   (gen_rise),
      .frame_sync_r (gen_fs)
   );

   // Bit tick: generated clock when running, else external clock
   wire ext_rise = bclk_s_r[1] & ~bclk_prev_r;
   wire bit_tick = clk_rst_n ? gen_rise : ext_rise;
   wire ext_fsx  = fsx_s_r[1] & ~fsx_prev_r;
   wire ext_fsr  = fsr_s_r[1] & ~fsr_prev_r;
   // Copy only into an empty shift register, so a queued word never overwrites one
   wire tx_copy  = bit_tick & ~tx_active_r & ~transmit_ready_flag_r & ~shift_reg_not_empty_flag_r;
   // Per-copy sync when mode is zero; generator otherwise
   wire fsx_int  = frame_generator_mode ? (gen_fs & gen_rise) : tx_copy; // R10
   wire fsx_ext  = ext_fsx;
   wire tx_sync  = transmitter_reset_n_n & ((clk_rst_n & fsx_int) | (~clk_rst_n & fsx_ext)); // R13
   wire rx_sync  = receiver_reset_n_n & (ext_fsr | (frame_rst_n & gen_fs & gen_rise));
   wire xrise    = transmitter_reset_n_n & ~transmitter_reset_n_q_r;

   wire wr_ctrl  = wr && addr == `ASP_ADDR_CTRL;
   wire wr_txd   = wr && addr == `ASP_ADDR_TXDATA;
   wire rd_rxd   = rd && addr == `ASP_ADDR_RXDATA;

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r       <= `ASP_CTRL_RESET; // R18
         srg_r        <= `ASP_SRG_RESET;
         pin_clock_mode_extension_r     <= 1'b0;
         rdata_r      <= 16'h0000;
         txd_r        <= {DATA_W{1'b0}};
         txsr_r       <= `ASP_TXSR_DEFAULT;
         rxsr_r       <= {DATA_W{1'b0}};
         rxd_r        <= {DATA_W{1'b0}};
         txcnt_r      <= 5'h00;
         rxcnt_r      <= 5'h00;
         transmit_ready_flag_r       <= 1'b0;
         receive_ready_flag_r       <= 1'b0;
         shift_reg_not_empty_flag_r     <= 1'b0;
         transmit_sync_error_r   <= 1'b0;
         first_en_r   <= 1'b1;
         errwin_r     <= 2'h0;
         tx_active_r  <= 1'b0;
         rx_active_r  <= 1'b0;
         transmitter_reset_n_q_r     <= 1'b0;
         first_sync_r <= 1'b0;
         fsx_prev_r   <= 1'b0;
         fsr_prev_r   <= 1'b0;
         bclk_prev_r  <= 1'b0;
         srcp_prev_r  <= 1'b0;
      end else begin
         fsx_prev_r  <= fsx_s_r[1];
         fsr_prev_r  <= fsr_s_r[1];
         bclk_prev_r <= bclk_s_r[1];
         srcp_prev_r <= src_s_r[1];
         transmitter_reset_n_q_r    <= transmitter_reset_n_n;
         // Software keeps sequencing order; writes are taken as given
         if (wr_ctrl)
            ctrl_r <= wdata[7:0]; // R1
         if (wr && addr == `ASP_ADDR_SRG)
            srg_r <= wdata[9:0]; // R1
         if (wr && addr == `ASP_ADDR_PIN)
            pin_clock_mode_extension_r <= wdata[`ASP_PIN_PIN_CLOCK_MODE_EXTENSION];
         if (rd) begin
            case (addr)
               `ASP_ADDR_CTRL:   rdata_r <= {8'h00, ctrl_r};
               `ASP_ADDR_SRG:    rdata_r <= {6'h00, srg_r};
               `ASP_ADDR_PIN:    rdata_r <= {15'h0000, pin_clock_mode_extension_r};
               `ASP_ADDR_TXDATA: rdata_r <= txd_r;
               `ASP_ADDR_RXDATA: rdata_r <= rxd_r;
               `ASP_ADDR_STATUS: rdata_r <= {12'h000, transmit_sync_error_r, shift_reg_not_empty_flag_r, receive_ready_flag_r, transmit_ready_flag_r};
               default:          rdata_r <= 16'h0000;
            endcase
         end else begin
            rdata_r <= 16'h0000;
         end

         // Transmitter
         if (!transmitter_reset_n_n) begin
            transmit_ready_flag_r      <= 1'b0;
            shift_reg_not_empty_flag_r    <= 1'b0;
            tx_active_r <= 1'b0;
            txcnt_r     <= 5'h00;
            errwin_r    <= 2'h0;
            txsr_r      <= `ASP_TXSR_DEFAULT; // R14
            transmit_sync_error_r  <= 1'b0; // R7
         end else begin
            if (xrise) begin
               transmit_ready_flag_r <= 1'b1; // R20
               if (first_en_r) begin
                  first_en_r <= 1'b0;
                  errwin_r   <= `ASP_SYNC_WINDOW; // R6
               end
            end
            if (wr_txd) begin
               txd_r  <= wdata[DATA_W-1:0];
               transmit_ready_flag_r <= 1'b0;
            end
            if (errwin_r != 2'h0 && bit_tick) begin
               errwin_r <= errwin_r - 2'h1;
               // Spurious error lands inside the two-clock window
               if (errwin_r == 2'h1 && tx_sync)
                  transmit_sync_error_r <= 1'b1; // R6
            end
            // Load ahead of the sync so software can see the word taken
            if (tx_copy) begin
               txsr_r   <= txd_r;
               shift_reg_not_empty_flag_r <= 1'b1;
               transmit_ready_flag_r   <= 1'b1;
            end
            if (tx_sync && !tx_active_r) begin
               // No word loaded: default shift content goes out
               tx_active_r <= 1'b1; // R14
               txcnt_r     <= 5'h00;
            end else if (tx_active_r && bit_tick) begin
               txsr_r  <= {txsr_r[DATA_W-2:0], 1'b0};
               txcnt_r <= txcnt_r + 5'h01;
               if (txcnt_r == DATA_W - 1) begin
                  tx_active_r <= 1'b0; // R13
                  shift_reg_not_empty_flag_r    <= 1'b0;
               end
            end
         end

         // Receiver
         if (!receiver_reset_n_n) begin
            receive_ready_flag_r      <= 1'b0;
            rx_active_r <= 1'b0;
            rxcnt_r     <= 5'h00;
         end else begin
            if (rd_rxd)
               receive_ready_flag_r <= 1'b0;
            if (rx_sync && !rx_active_r) begin
               rx_active_r <= 1'b1;
               rxcnt_r     <= 5'h00;
            end else if (rx_active_r && bit_tick) begin
               rxsr_r  <= {rxsr_r[DATA_W-2:0], dr_s_r[1]};
               rxcnt_r <= rxcnt_r + 5'h01;
               if (rxcnt_r == DATA_W - 1) begin
                  rx_active_r <= 1'b0;
                  rxd_r       <= {rxsr_r[DATA_W-2:0], dr_s_r[1]};
                  receive_ready_flag_r      <= 1'b1; // R9
               end
            end
         end
         first_sync_r <= ext_fsx;
      end
   end

   // Pins and service requests, all registered
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tx_data_r            <= 1'b0;
         tx_data_oe_r         <= 1'b0;
         bit_clk_out_r        <= 1'b0;
         fsx_out_r            <= 1'b0;
         fsr_out_r            <= 1'b0;
         transmit_dma_event_r <= 1'b0;
         receive_dma_event_r  <= 1'b0;
         transmit_interrupt_r <= 1'b0;
         receive_interrupt_r  <= 1'b0;
      end else begin
         tx_data_r     <= txsr_r[DATA_W-1];
         tx_data_oe_r  <= transmitter_reset_n_n;
         bit_clk_out_r <= gen_clk; // R19
         // Inactive while the section sits in reset
         fsx_out_r     <= transmitter_reset_n_n & (frame_generator_mode ? gen_fs : tx_copy); // R10
         fsr_out_r     <= receiver_reset_n_n & frame_rst_n & gen_fs;
         transmit_dma_event_r <= transmitter_reset_n_n & transmit_ready_flag_r; // R9
         receive_dma_event_r  <= receiver_reset_n_n & receive_ready_flag_r; // R9
         case (transmit_interrupt_mode)
            `ASP_INTM_READY:   transmit_interrupt_r <= transmitter_reset_n_n & transmit_ready_flag_r; // R9
            `ASP_INTM_FSYNC:   transmit_interrupt_r <= transmitter_reset_n_n & tx_sync; // R16
            `ASP_INTM_SYNCERR: transmit_interrupt_r <= transmitter_reset_n_n & transmit_sync_error_r;
            default:           transmit_interrupt_r <= 1'b0;
         endcase
         case (receive_interrupt_mode)
            `ASP_INTM_READY:   receive_interrupt_r <= receiver_reset_n_n & receive_ready_flag_r; // R9
            `ASP_INTM_FSYNC:   receive_interrupt_r <= receiver_reset_n_n & rx_sync; // R16
            default:           receive_interrupt_r <= 1'b0;
         endcase
      end
   end

endmodule

`default_nettype wire

/* File: verif/asp_init_props.sv */
// Checker of the sequencer pins against a shadow of software writes.
// Assumes binding to asp_init_core; the shadow lags a write by one cycle.
`timescale 1ns/1ps
`default_nettype none
`include "asp_init_map.vh"
module asp_init_props #(
   parameter DIV_W = 8
) (
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic [3:0]  addr,
   input wire logic [15:0] wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [15:0] rdata_r,
   input wire logic        bit_clk_out_r,
   input wire logic        fsx_out_r,
   input wire logic        tx_data_oe_r,
   input wire logic        transmit_dma_event_r,
   input wire logic        transmit_interrupt_r
);
   logic [7:0] ctl_r;
   logic [9:0] srg_r, per_r;
   logic [3:0] fcnt_r;
   logic       pin_r, wctl_r, seen_r, fs_r, bq_r;
   wire        brise = bit_clk_out_r && !bq_r;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctl_r  <= 8'h00;
         srg_r  <= 10'h001;
         per_r  <= 10'h000;
         fcnt_r <= 4'h0;
         pin_r  <= 1'b0;
         wctl_r <= 1'b0;
         seen_r <= 1'b0;
         fs_r   <= 1'b0;
         bq_r   <= 1'b0;
      end else begin
         bq_r  <= bit_clk_out_r;
         per_r <= brise ? 10'h001 : per_r + 10'h001;
         if (brise) seen_r <= 1'b1;
         if (brise && fcnt_r != 4'hF) fcnt_r <= fcnt_r + 4'h1;
         if (fsx_out_r) fs_r <= 1'b1;
         // First rise after a restart has no valid period behind it
         if (!ctl_r[`ASP_CTL_CLOCK_GEN_RESET_N]) seen_r <= 1'b0;
         if (!ctl_r[`ASP_CTL_FRAME_GEN_RESET_N]) begin
            fcnt_r <= 4'h0;
            fs_r   <= 1'b0;
         end
         if (wr && addr == `ASP_ADDR_CTRL) begin
            ctl_r  <= wdata[7:0];
            wctl_r <= 1'b1;
         end
         if (wr && addr == `ASP_ADDR_SRG) srg_r <= wdata[9:0];
         if (wr && addr == `ASP_ADDR_PIN) pin_r <= wdata[0];
      end
   end
   reset_idle_a:
   assert property ($rose(rst_n) |-> !bit_clk_out_r && !fsx_out_r && !tx_data_oe_r)
      else $error("outputs active after reset");
   ctl_zero_a:
   assert property (rd && addr == `ASP_ADDR_CTRL && !wctl_r |=> rdata_r[3:0] == 4'h0)
      else $error("reset bits not zero");
   clk_held_a:
   assert property ((!ctl_r[`ASP_CTL_CLOCK_GEN_RESET_N]) [*3] |-> !bit_clk_out_r)
      else $error("bit clock runs in reset");
   clk_period_a:
   assert property ($rose(bit_clk_out_r) && seen_r && !(srg_r[8] ^ pin_r)
      |-> per_r == {2'b00, srg_r[DIV_W-1:0]} + 10'h001)
      else $error("bit clock period wrong");
   tx_ready_a:
   assert property (wr && addr == `ASP_ADDR_CTRL && wdata[`ASP_CTL_TRANSMITTER_RESET_N]
      && !ctl_r[`ASP_CTL_TRANSMITTER_RESET_N] |-> ##[1:4] transmit_dma_event_r)
      else $error("no ready after release");
   tx_quiet_a:
   assert property ((!ctl_r[`ASP_CTL_TRANSMITTER_RESET_N]) [*3]
      |-> !tx_data_oe_r && !transmit_dma_event_r && !fsx_out_r)
      else $error("transmitter active in reset");
   fsync_int_a:
   assert property ((ctl_r[5:4] == `ASP_INTM_FSYNC && !ctl_r[`ASP_CTL_TRANSMITTER_RESET_N]) [*3]
      |-> !transmit_interrupt_r)
      else $error("sync interrupt in reset");
   err_clear_a:
   assert property (rd && addr == `ASP_ADDR_STATUS && !ctl_r[`ASP_CTL_TRANSMITTER_RESET_N]
      |=> !rdata_r[`ASP_ST_TRANSMIT_SYNC_ERROR])
      else $error("sync error not cleared");
   fs_early_a:
   assert property (ctl_r[`ASP_CTL_FRAME_GEN_RESET_N] && srg_r[9] && fcnt_r < 4'h6 |-> !fsx_out_r)
      else $error("frame sync too early");
   fs_late_a:
   assert property (ctl_r[`ASP_CTL_FRAME_GEN_RESET_N] && srg_r[9] && ctl_r[`ASP_CTL_TRANSMITTER_RESET_N]
      && fcnt_r == 4'hB |-> fs_r)
      else $error("frame sync too late");
   cover property ($rose(bit_clk_out_r) && seen_r);
   cover property ($rose(fsx_out_r) && srg_r[9]);
   cover property (rd && addr == `ASP_ADDR_STATUS && ctl_r[`ASP_CTL_TRANSMITTER_RESET_N]);
endmodule
bind asp_init_core asp_init_props #(.DIV_W(DIV_W)) i_asp_init_props (
   .mclk, .rst_n, .addr, .wdata, .wr, .rd, .rdata_r, .bit_clk_out_r, .fsx_out_r,
   .tx_data_oe_r, .transmit_dma_event_r, .transmit_interrupt_r
);
`default_nettype wire

/* File: verif/asp_codec_model.sv */
// Far-side codec model: source clock, bit clock, frame syncs, receive data.
// Assumes the bench opens frames with clk_en and asks for each sync.
`timescale 1ns/1ps
`default_nettype none
module asp_codec_model #(
   parameter int HALF = 3
) (
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic clk_en,
   input  wire logic fs_go,
   output logic      src_clk,
   output logic      bit_clk,
   output logic      transmit_frame_sync,
   output logic      receive_frame_sync,
   output logic      rx_data
);
   int   cnt;
   logic pend;
   wire  tick = (cnt == HALF - 1);
   assign receive_frame_sync = transmit_frame_sync;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt     <= 0;
         src_clk <= 1'b0;
         bit_clk <= 1'b0;
         transmit_frame_sync     <= 1'b0;
         pend    <= 1'b0;
         rx_data <= 1'b0;
      end else begin
         cnt <= tick ? 0 : cnt + 1;
         // Nothing received: a moving pattern, never a stale level
         rx_data <= ~rx_data;
         if (tick) src_clk <= ~src_clk;
         if (fs_go) pend <= 1'b1;
         if (!clk_en) begin
            bit_clk <= 1'b0;
            transmit_frame_sync     <= 1'b0;
         end else if (tick) begin
            bit_clk <= ~bit_clk;
            if (!bit_clk) transmit_frame_sync <= pend;
            if (!bit_clk) pend <= fs_go;
         end
      end
   end
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// Bench of the serial port sequencer: reset, clocks and start-up flows.
// Assumes the codec model on the pins and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "asp_init_map.vh"
module testbench;
   logic        mclk, rst_n, wr, rd, clk_en, fs_go;
   logic [3:0]  addr;
   logic [15:0] wdata, v, rdata;
   logic        src_clk, e_bclk, e_fsx, e_fsr, rx_d, tx_d, tx_oe, bclk, transmit_frame_sync, transmit_dma_event, transmit_interrupt;
   int          n_errors, cmp_count, n, p;
   asp_init_core i_asp_init_core (
      .mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata_r(rdata), .src_clk_pin(src_clk), .ext_bit_clk_pin(e_bclk),
      .ext_fsx_pin(e_fsx), .ext_fsr_pin(e_fsr), .rx_data_pin(rx_d), .tx_data_r(tx_d),
      .tx_data_oe_r(tx_oe), .bit_clk_out_r(bclk), .fsx_out_r(transmit_frame_sync), .fsr_out_r(),
      .transmit_dma_event_r(transmit_dma_event), .receive_dma_event_r(),
      .transmit_interrupt_r(transmit_interrupt), .receive_interrupt_r()
   );
   asp_codec_model i_asp_codec_model (
      .mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .fs_go(fs_go), .src_clk(src_clk),
      .bit_clk(e_bclk), .transmit_frame_sync(e_fsx), .receive_frame_sync(e_fsr), .rx_data(rx_d)
   );
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wreg(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task automatic rchk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
      @(posedge mclk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      chk(rdata & m, e);
   endtask
   // Bounded: returns after the next rising edge of the generated clock
   task automatic rise(inout int c);
      logic q;
      q = 1'b1;
      repeat (400) begin
         @(posedge mclk);
         #1;
         c++;
         if (q === 1'b0 && bclk === 1'b1) return;
         q = bclk;
      end
      n_errors++;
   endtask
   task automatic wfs(ref logic s, output int c);
      c = 0;
      while (s !== 1'b1 && c < 300) begin
         @(posedge mclk);
         #1;
         c++;
      end
   endtask
   task automatic watch(input int k, output logic [15:0] s);
      s = 16'h0000;
      repeat (k) begin
         @(posedge mclk);
         #1;
         s = s | 16'(tx_d);
      end
   endtask
   task automatic send_fs;
      @(posedge mclk);
      fs_go <= 1'b1;
      @(posedge mclk);
      fs_go <= 1'b0;
   endtask
   task automatic give_verdict;
      $display("TB: errors=%0d compares=%0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   // Whole run is well under a thousand cycles; this limit is 25000 cycles
   initial begin
      #100000;
      n_errors++;
      give_verdict;
   end
   initial begin
      rst_n  = 1'b0;
      wr     = 1'b0;
      rd     = 1'b0;
      addr   = 4'h0;
      wdata  = 16'h0000;
      clk_en = 1'b0;
      fs_go  = 1'b0;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      rchk(`ASP_ADDR_CTRL, 16'h00FF, 16'h0000);
      rchk(`ASP_ADDR_SRG, 16'h03FF, 16'h0001);
      rchk(`ASP_ADDR_STATUS, 16'h000F, 16'h0000);
      wreg(4'hF, 16'hFFFF);
      rchk(4'hF, 16'hFFFF, 16'h0000);
      $display("TB: test 1 done");
      for (int i = 0; i < 4; i++) begin
         wreg(`ASP_ADDR_CTRL, 16'h0000);
         wreg(`ASP_ADDR_SRG, {7'h00, i[1], 8'h01});
         wreg(`ASP_ADDR_PIN, {15'h0000, i[0]});
         repeat (12) @(posedge mclk);
         wreg(`ASP_ADDR_CTRL, 16'h0004);
         rise(p);
         p = 0;
         rise(p);
         chk(16'(p), (i[1] ^ i[0]) ? 16'h000C : 16'h0002);
      end
      $display("TB: test 2 done");
      wreg(`ASP_ADDR_CTRL, 16'h0006);
      rchk(`ASP_ADDR_STATUS, 16'h0001, 16'h0001);
      chk(16'(transmit_dma_event), 16'h0001);
      chk(16'(transmit_interrupt), 16'h0001);
      repeat (4) @(posedge mclk);
      wreg(`ASP_ADDR_CTRL, 16'h0004);
      rchk(`ASP_ADDR_STATUS, 16'h0008, 16'h0000);
      wreg(`ASP_ADDR_CTRL, 16'h0006);
      rchk(`ASP_ADDR_STATUS, 16'h0001, 16'h0001);
      wreg(`ASP_ADDR_TXDATA, 16'hA5C3);
      wfs(transmit_frame_sync, n);
      chk(16'(transmit_frame_sync), 16'h0001);
      $display("TB: test 3 done");
      wreg(`ASP_ADDR_CTRL, 16'h0000);
      wreg(`ASP_ADDR_SRG, 16'h0301);
      repeat (4) @(posedge mclk);
      wreg(`ASP_ADDR_CTRL, 16'h0004);
      repeat (4) @(posedge mclk);
      wreg(`ASP_ADDR_CTRL, 16'h0006);
      rchk(`ASP_ADDR_STATUS, 16'h0001, 16'h0001);
      wreg(`ASP_ADDR_TXDATA, 16'h5A3C);
      repeat (8) @(posedge mclk);
      rchk(`ASP_ADDR_STATUS, 16'h0004, 16'h0004);
      wreg(`ASP_ADDR_CTRL, 16'h000E);
      wfs(transmit_frame_sync, n);
      chk(16'(n >= 10 && n <= 24), 16'h0001);
      $display("TB: test 4 done");
      wreg(`ASP_ADDR_CTRL, 16'h0000);
      wreg(`ASP_ADDR_SRG, 16'h0101);
      clk_en <= 1'b1;
      for (int m = 2; m < 4; m++) begin
         wreg(`ASP_ADDR_CTRL, 16'(m << 4) | 16'h0004);
         send_fs;
         repeat (40) @(posedge mclk);
         chk(16'(transmit_interrupt), 16'h0000);
      end
      send_fs;
      wfs(e_fsx, n);
      // Let the first sync pass the pin stages before release
      repeat (4) @(posedge mclk);
      wreg(`ASP_ADDR_CTRL, 16'h0002);
      watch(30, v);
      chk(v, 16'h0000);
      send_fs;
      watch(100, v);
      chk(v, 16'h0000);
      rchk(`ASP_ADDR_STATUS, 16'h0001, 16'h0001);
      wreg(`ASP_ADDR_TXDATA, 16'hA5C3);
      send_fs;
      watch(150, v);
      chk(v, 16'h0001);
      chk(16'(tx_oe), 16'h0001);
      clk_en <= 1'b0;
      $display("TB: test 5 done");
      give_verdict;
   end
endmodule
`default_nettype wire
